//--- icc_pkg.sv
// Constants shared by the input capture channel block
package icc_pkg;
  localparam int          ICC_CHANNELS   = 8;
  localparam int          ICC_DEPTH      = 4;
  // Register indices on the plain port
  localparam logic [4:0]  ICC_CH_BASE    = 5'h00;
  localparam logic [4:0]  ICC_IRQ_STAT   = 5'h10;
  localparam logic [4:0]  ICC_IRQ_EN     = 5'h11;
  localparam logic [4:0]  ICC_IRQ_CLR    = 5'h12;
  localparam logic [4:0]  ICC_WAKE_STAT  = 5'h13;
  // Control register fields
  localparam int          ICC_IDLE_BIT   = 13;
  localparam int          ICC_TMR_BIT    = 7;
  localparam int          ICC_CPI_LSB    = 5;
  localparam int          ICC_OVF_BIT    = 4;
  localparam int          ICC_BNE_BIT    = 3;
  localparam int          ICC_MODE_LSB   = 0;
  localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;
  localparam logic [3:0]  ICC_PRE4_LAST  = 4'h3;
  localparam logic [3:0]  ICC_PRE16_LAST = 4'hf;
  typedef enum logic [2:0] {
    ICC_MODE_OFF     = 3'b000,
    ICC_MODE_BOTH    = 3'b001,
    ICC_MODE_FALL    = 3'b010,
    ICC_MODE_RISE    = 3'b011,
    ICC_MODE_RISE4   = 3'b100,
    ICC_MODE_RISE16  = 3'b101,
    ICC_MODE_UNUSED  = 3'b110,
    ICC_MODE_WAKE    = 3'b111
  } icc_mode_type;
endpackage : icc_pkg

//--- icc_top.sv
// Eight input capture channels with FIFO, interrupt and wake logic
//
// How it works
// - Each qualifying edge copies the selected 16-bit timer count into the buffer unless it is full.
// - Timebase select bit 7 picks first timer when set, second when clear.
// - Captures-per-interrupt field interrupts every 1, 2, 3 or 4 captures.
// - Mode 001 captures both edges and interrupts on every capture.
// - Mode 010 captures falling edges, mode 011 rising edges.
// - Mode 100 captures every fourth, mode 101 every sixteenth rising edge.
// - Modes 110 and 000 leave the channel disabled.
// - Mode 111 makes rising edges an interrupt only in Sleep or Idle.
// - Read-only overflow flag bit 4, cleared by hardware, resets to zero.
// - Read-only bit 3 is set while the buffer holds an unread value.
// - Captured values sit in a four word first-in first-out buffer.
// - Idle-halt bit 13 stops the channel in Idle, else it runs on.
// - Capture pin events can wake the device from Sleep and Idle.
// - Eight independent channels, each selecting one of two 16-bit timers.
// - Writable control bits reset to zero, unimplemented bits read zero.
`timescale 1ns/1ps
`default_nettype none

module icc_channel
  import icc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        pin_in,
  input  wire logic [15:0] first_count_in,
  input  wire logic [15:0] second_count_in,
  input  wire logic [15:0] ctrl_in,
  input  wire logic        pop_in,
  input  wire logic        cpu_idle_in,
  input  wire logic        cpu_sleep_in,
  output logic      [15:0] head_out,
  output logic             bne_out,
  output logic             ovf_out,
  output logic             event_out,
  output logic             wake_out
);
  logic [1:0]   sync;
  logic         prev;
  logic         rise;
  logic         fall;
  logic [3:0]   pre_cnt;
  logic [1:0]   irq_cnt;
  logic         capture;
  logic         run;
  logic [15:0]  fifo [ICC_DEPTH];
  logic [1:0]   wr_ptr;
  logic [1:0]   rd_ptr;
  logic [2:0]   count;
  logic         full;
  logic         do_pop;
  logic         push;
  logic         irq_due;
  logic         wake_due;
  logic [15:0]  stamp;
  icc_mode_type mode;

  assign mode  = icc_mode_type'(ctrl_in[ICC_MODE_LSB +: 3]);
  assign rise  = sync[1] & ~prev;
  assign fall  = ~sync[1] & prev;
  assign full  = (count == 3'(ICC_DEPTH));
  assign stamp = ctrl_in[ICC_TMR_BIT] ? first_count_in : second_count_in;
  // Halted in Sleep, and in Idle when idle-halt is set
  assign run   = ~cpu_sleep_in & ~(cpu_idle_in & ctrl_in[ICC_IDLE_BIT]);

  // Two-stage pin synchroniser, edges seen from stage two only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync <= 2'b00;
    end else begin
      sync <= {sync[0], pin_in};
    end
  end

  // Delayed copy of stage two for edge detection
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev <= 1'b0;
    end else begin
      prev <= sync[1];
    end
  end

  // Edge prescaler for divided modes
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt <= 4'h0;
    end else if (mode != ICC_MODE_RISE4 && mode != ICC_MODE_RISE16) begin
      pre_cnt <= 4'h0;
    end else if (run && rise) begin
      if ((mode == ICC_MODE_RISE4 && pre_cnt == ICC_PRE4_LAST) ||
          (mode == ICC_MODE_RISE16 && pre_cnt == ICC_PRE16_LAST)) begin
        pre_cnt <= 4'h0;
      end else begin
        pre_cnt <= pre_cnt + 4'h1;
      end
    end
  end

  // Qualifying capture event per mode
  always_comb begin
    capture = 1'b0;
    case (mode)
      ICC_MODE_BOTH:   capture = run & (rise | fall);
      ICC_MODE_FALL:   capture = run & fall;
      ICC_MODE_RISE:   capture = run & rise;
      ICC_MODE_RISE4:  capture = run & rise & (pre_cnt == ICC_PRE4_LAST);
      ICC_MODE_RISE16: capture = run & rise & (pre_cnt == ICC_PRE16_LAST);
      default:         capture = 1'b0;
    endcase
  end

  // Reading an empty buffer changes nothing
  assign do_pop = pop_in & (count != 3'h0);
  assign push   = capture & ~full;

  // Four word FIFO, full buffer keeps its entries
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= 2'h0;
    end else if (mode == ICC_MODE_OFF) begin
      wr_ptr <= 2'h0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_ptr <= 2'h0;
    end else if (mode == ICC_MODE_OFF) begin
      rd_ptr <= 2'h0;
    end else if (do_pop) begin
      rd_ptr <= rd_ptr + 2'h1;
    end
  end

  // Fill level, push and pop may share a cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= 3'h0;
    end else if (mode == ICC_MODE_OFF) begin
      count <= 3'h0;
    end else begin
      count <= count + 3'(push) - 3'(do_pop);
    end
  end

  // Storage needs no reset, the fill level guards it
  always_ff @(posedge clk_in) begin
    if (push) begin
      fifo[wr_ptr] <= stamp;
    end
  end

  assign head_out = (count != 3'h0) ? fifo[rd_ptr] : 16'h0000;
  assign bne_out  = (count != 3'h0);

  // Overflow: set on capture into full buffer, cleared by a read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ovf_out <= 1'b0;
    end else if (capture && full) begin
      ovf_out <= 1'b1;
    end else if (do_pop || mode == ICC_MODE_OFF) begin
      ovf_out <= 1'b0;
    end
  end

  // Interrupt and wake pulses due this cycle
  always_comb begin
    irq_due  = 1'b0;
    wake_due = 1'b0;
    if (mode == ICC_MODE_WAKE) begin
      irq_due  = rise & (cpu_sleep_in | cpu_idle_in);
      wake_due = rise & (cpu_sleep_in | cpu_idle_in);
    end else if (capture) begin
      wake_due = cpu_idle_in;
      if (mode == ICC_MODE_BOTH) begin
        irq_due = 1'b1;
      end else begin
        irq_due = (irq_cnt == ctrl_in[ICC_CPI_LSB +: 2]);
      end
    end
  end

  // Captures counted towards the next interrupt
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_cnt <= 2'h0;
    end else if (mode == ICC_MODE_WAKE || mode == ICC_MODE_OFF) begin
      irq_cnt <= 2'h0;
    end else if (capture) begin
      irq_cnt <= irq_due ? 2'h0 : irq_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      event_out <= 1'b0;
    end else begin
      event_out <= irq_due;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= wake_due;
    end
  end
endmodule : icc_channel

module icc_top
  import icc_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic [4:0]              addr_in,
  input  wire logic [15:0]             wr_data_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  input  wire logic [ICC_CHANNELS-1:0] capture_input_pin_in,
  input  wire logic [15:0]             first_timebase_count_in,
  input  wire logic [15:0]             second_timebase_count_in,
  input  wire logic                    cpu_idle_in,
  input  wire logic                    cpu_sleep_in,
  output logic      [15:0]             rd_data_out,
  output logic                         irq_out,
  output logic                         wake_out
);
  logic [15:0]             ctrl     [ICC_CHANNELS];
  logic [15:0]             head     [ICC_CHANNELS];
  logic [ICC_CHANNELS-1:0] bne;
  logic [ICC_CHANNELS-1:0] ovf;
  logic [ICC_CHANNELS-1:0] evt;
  logic [ICC_CHANNELS-1:0] wake;
  logic [ICC_CHANNELS-1:0] pop;
  logic [ICC_CHANNELS-1:0] irq_stat;
  logic [ICC_CHANNELS-1:0] irq_en;
  logic [ICC_CHANNELS-1:0] next_irq_stat;
  logic [ICC_CHANNELS-1:0] clr_mask;
  logic [ICC_CHANNELS-1:0] wake_stat;
  logic [15:0]             next_rd_data;
  logic                    ch_hit;
  logic [2:0]              ch_sel;

  // Channel n: control at 2n, buffer at 2n+1
  assign ch_hit = (addr_in[4] == ICC_CH_BASE[4]);
  assign ch_sel = addr_in[3:1];

  genvar g;
  generate
    for (g = 0; g < ICC_CHANNELS; g++) begin : gen_ch
      assign pop[g] = rd_in & ch_hit & addr_in[0] & (ch_sel == 3'(g));

      // Writable bits only; flags are read-only
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl[g] <= ICC_CTRL_RESET;
        end else if (wr_in && ch_hit && !addr_in[0] && ch_sel == 3'(g)) begin
          ctrl[g] <= {2'b00, wr_data_in[ICC_IDLE_BIT], 5'h00,
                      wr_data_in[ICC_TMR_BIT:ICC_CPI_LSB], 2'b00,
                      wr_data_in[ICC_MODE_LSB +: 3]};
        end
      end

      icc_channel u_ch (
        .clk_in          (clk_in),
        .rst_in          (rst_in),
        .pin_in          (capture_input_pin_in[g]),
        .first_count_in  (first_timebase_count_in),
        .second_count_in (second_timebase_count_in),
        .ctrl_in         (ctrl[g]),
        .pop_in          (pop[g]),
        .cpu_idle_in     (cpu_idle_in),
        .cpu_sleep_in    (cpu_sleep_in),
        .head_out        (head[g]),
        .bne_out         (bne[g]),
        .ovf_out         (ovf[g]),
        .event_out       (evt[g]),
        .wake_out        (wake[g])
      );
    end
  endgenerate

  // Clear mask from the write-only clear register
  assign clr_mask = (wr_in && addr_in == ICC_IRQ_CLR) ? wr_data_in[ICC_CHANNELS-1:0] : '0;

  // Sticky status, set beats clear
  assign next_irq_stat = evt | (irq_stat & ~clr_mask);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Level interrupt follows the enabled status
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(next_irq_stat & irq_en);
    end
  end

  // Enable register, same layout as the status
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en <= '0;
    end else if (wr_in && addr_in == ICC_IRQ_EN) begin
      irq_en <= wr_data_in[ICC_CHANNELS-1:0];
    end
  end

  // Wake request, sticky until the channel bit is written in the clear register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_stat <= '0;
    end else begin
      wake_stat <= wake | (wake_stat & ~clr_mask);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= |wake;
    end
  end

  // Read mux, data stand in the cycle after the strobe only
  always_comb begin
    next_rd_data = 16'h0000;
    if (ch_hit) begin
      if (addr_in[0]) begin
        next_rd_data = head[ch_sel];
      end else begin
        next_rd_data = ctrl[ch_sel];
        next_rd_data[ICC_OVF_BIT] = ovf[ch_sel];
        next_rd_data[ICC_BNE_BIT] = bne[ch_sel];
      end
    end else begin
      case (addr_in)
        ICC_IRQ_STAT:  next_rd_data = {8'h00, irq_stat};
        ICC_IRQ_EN:    next_rd_data = {8'h00, irq_en};
        ICC_WAKE_STAT: next_rd_data = {8'h00, wake_stat};
        default:       next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_in) begin
      rd_data_out <= next_rd_data;
    end else begin
      rd_data_out <= 16'h0000;
    end
  end
endmodule : icc_top

`default_nettype wire

//--- icc_chk.sv
// Port-level assertions for the input capture block
`timescale 1ns/1ps
`default_nettype none
module icc_chk
  import icc_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [4:0]  addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        cpu_idle_in,
  input wire logic        cpu_sleep_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        irq_out,
  input wire logic        wake_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_ctl_wr; wr_in && addr_in < ICC_IRQ_STAT && !addr_in[0]; endsequence
  sequence s_ctl_rd; rd_in && addr_in < ICC_IRQ_STAT && !addr_in[0]; endsequence
  sequence s_buf_rd; rd_in && addr_in < ICC_IRQ_STAT && addr_in[0]; endsequence
  property p_reset_quiet;
    $fell(rst_in) |-> !irq_out && !wake_out && rd_data_out == 16'h0000;
  endproperty
  property p_readback;
    s_ctl_wr ##2 (rd_in && addr_in == $past(addr_in, 2))
      |=> (rd_data_out & 16'h20e7) == ($past(wr_data_in, 3) & 16'h20e7);
  endproperty
  property p_ctl_zero;
    s_ctl_rd |=> rd_data_out[15:14] == 2'b00 && rd_data_out[12:8] == 5'h00;
  endproperty
  property p_empty;
    s_ctl_rd ##1 !rd_data_out[ICC_BNE_BIT] ##1 (rd_in && addr_in == $past(addr_in, 2) + 5'h01)
      |=> rd_data_out == 16'h0000;
  endproperty
  property p_ovf_clr;
    s_buf_rd ##2 (rd_in && addr_in == $past(addr_in, 2) - 5'h01) |=> !rd_data_out[ICC_OVF_BIT];
  endproperty
  property p_irq_off;
    wr_in && addr_in == ICC_IRQ_EN && wr_data_in[7:0] == 8'h00 |=> ##1 !irq_out;
  endproperty
  property p_unmapped;
    rd_in && addr_in > ICC_WAKE_STAT |=> rd_data_out == 16'h0000;
  endproperty
  property p_rd_gap;
    !rd_in |=> rd_data_out == 16'h0000;
  endproperty
  property p_wake;
    wake_out |-> $past(cpu_idle_in, 2) || $past(cpu_sleep_in, 2);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  a_readback: assert property (p_readback) else $error("control readback wrong");
  a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bits set");
  a_empty: assert property (p_empty) else $error("empty buffer read not zero");
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow kept after read");
  a_irq_off: assert property (p_irq_off) else $error("irq high while masked");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rd_gap: assert property (p_rd_gap) else $error("read data without strobe");
  a_wake: assert property (p_wake) else $error("wake outside sleep or idle");
endmodule : icc_chk
bind icc_top icc_chk u_chk (.clk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
  .cpu_idle_in, .cpu_sleep_in, .rd_data_out, .irq_out, .wake_out);
`default_nettype wire

//--- icc_pin_model.sv
// Behavioural driver of the external capture pins
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] flip_in,
  output logic      [7:0] pin_out
);
  // Each request flips one level; bench keeps levels many cycles wide
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) pin_out <= 8'h00;
    else pin_out <= pin_out ^ flip_in;
  end
endmodule : icc_pin_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the input capture block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import icc_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic        cpu_idle_in = 1'b0, cpu_sleep_in = 1'b0, irq_out, wake_out;
  logic [4:0]  addr_in = 5'h00;
  logic [15:0] wr_data_in = 16'h0000, first_in = 16'h0000, second_in = 16'h0000;
  logic [15:0] rd_data_out, got;
  logic [7:0]  flip = 8'h00, pins;
  logic [15:0] q[$];
  int          n_mismatch = 0, cmp_count = 0, n_wake = 0;
  icc_pin_model u_pins (.clk_in(clk_in), .rst_in(rst_in), .flip_in(flip), .pin_out(pins));
  icc_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .capture_input_pin_in(pins), .first_timebase_count_in(first_in),
    .second_timebase_count_in(second_in), .cpu_idle_in(cpu_idle_in),
    .cpu_sleep_in(cpu_sleep_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
    .wake_out(wake_out));
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (wake_out === 1'b1) n_wake++;
  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 got = rd_data_out;
    @(posedge clk_in);
  endtask : rd
  // New random timer counts stay put until the capture has landed
  task automatic flip_pin(input int c, input bit take, input bit sel);
    logic [15:0] a;
    logic [15:0] b;
    a = 16'($urandom);
    b = 16'($urandom);
    first_in <= a;
    second_in <= b;
    flip <= 8'h01 << c;
    @(posedge clk_in);
    flip <= 8'h00;
    repeat (8) @(posedge clk_in);
    if (take) q.push_back(sel ? a : b);
  endtask : flip_pin
  task automatic pulse(input int c);
    flip_pin(c, 1'b0, 1'b0);
    flip_pin(c, 1'b0, 1'b0);
  endtask : pulse
  function automatic bit qual(input logic [2:0] m, input bit rise, input int nr);
    case (m)
      3'b001: return 1'b1;
      3'b010: return !rise;
      3'b011: return rise;
      3'b100: return rise && nr % 4 == 0;
      3'b101: return rise && nr % 16 == 0;
      default: return 1'b0;
    endcase
  endfunction : qual
  initial begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    close_out();
  end
  initial begin
    int c;
    int n;
    int nr;
    bit s;
    void'($urandom(32'h46204691));
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int a = 0; a < 32; a++) if (a != 18) begin
      rd(5'(a));
      chk(got, 16'h0000);
    end
    wr(5'h02, 16'hffff);
    rd(5'h02);
    chk(got, 16'h20e7);
    wr(5'h02, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      c = $urandom_range(7);
      s = 1'($urandom_range(1));
      nr = 0;
      q.delete();
      wr(5'(2 * c), {8'h00, s, 4'h0, 3'(m)});
      for (int k = 0; k < 32; k++) begin
        nr += (k % 2 == 0);
        flip_pin(c, qual(3'(m), k % 2 == 0, nr), s);
      end
      n = q.size();
      rd(5'(2 * c));
      chk(got, {8'h00, s, 2'b00, n > 4, n > 0, 3'(m)});
      for (int j = 0; j < 5; j++) begin
        rd(5'(2 * c + 1));
        chk(got, (j < n && j < 4) ? q[j] : 16'h0000);
      end
      rd(5'(2 * c));
      chk(got, {8'h00, s, 7'(m)});
      wr(5'(2 * c), 16'h0000);
    end
    wr(ICC_IRQ_CLR, 16'h00ff);
    wr(ICC_IRQ_EN, 16'h00ff);
    for (int i = 0; i < 5; i++) begin
      n = (i < 4) ? i + 1 : 1;
      wr(ICC_CH_BASE, (i < 4) ? {9'h000, 2'(i), 5'h03} : 16'h0061);
      for (int k = 1; k <= n; k++) begin
        pulse(0);
        chk(16'(irq_out), 16'(k == n));
      end
      wr(ICC_IRQ_CLR, 16'h00ff);
      wr(ICC_CH_BASE, 16'h0000);
      chk(16'(irq_out), 16'h0000);
    end
    wr(ICC_IRQ_EN, 16'h0000);
    wr(ICC_CH_BASE, 16'h0003);
    pulse(0);
    chk(16'(irq_out), 16'h0000);
    rd(ICC_IRQ_STAT);
    chk(got, 16'h0001);
    wr(ICC_IRQ_EN, 16'h0001);
    @(posedge clk_in);
    chk(16'(irq_out), 16'h0001);
    wr(ICC_IRQ_CLR, 16'h0001);
    wr(ICC_CH_BASE, 16'h0000);
    cpu_idle_in <= 1'b1;
    wr(5'h02, 16'h2003);
    pulse(1);
    rd(5'h02);
    chk(got, 16'h2003);
    wr(5'h02, 16'h0003);
    n = n_wake;
    pulse(1);
    rd(5'h02);
    chk(got, 16'h000b);
    chk(16'(n_wake), 16'(n + 1));
    wr(5'h02, 16'h0000);
    wr(ICC_IRQ_CLR, 16'h00ff);
    cpu_idle_in <= 1'b0;
    cpu_sleep_in <= 1'b1;
    wr(5'h02, 16'h0007);
    n = n_wake;
    pulse(1);
    rd(ICC_IRQ_STAT);
    chk(got, 16'h0002);
    chk(16'(n_wake), 16'(n + 1));
    rd(5'h02);
    chk(got, 16'h0007);
    rd(ICC_WAKE_STAT);
    chk(got, 16'h0002);
    close_out();
  end
endmodule : tb
`default_nettype wire
